// ===== src/gmb_top.sv
`timescale 1ns/1ps
module gmb_top #(
    parameter int NPIN = gmb_pkg::NPIN,
    parameter int DEB_CYCLES = gmb_pkg::DEB_CYCLES
) (
    input wire logic sys_clk, // 40 MHz core clock
    input wire logic rst_n, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [gmb_pkg::AW-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [NPIN-1:0] pinIn, // pin input levels
    output logic [NPIN-1:0] pinOut, // pin output levels
    output logic [NPIN-1:0] pinOutEn_n, // low while driving
    input wire logic [NPIN-1:0] seqAssert, // sequencer asserts
    input wire logic blinkPulse, // blink generator pulse
    input wire logic fbReady, // external feedback state
    input wire logic supplyFault, // supply fault asserted
    input wire logic vsysMonitor, // system voltage monitor
    output logic [NPIN-1:0] pinActive, // inputs asserted
    output logic sysEnable, // system enable input
    output logic pwrEnable, // power enable input
    output logic pwr1Enable // secondary power enable
);
    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    logic [7:0] modeLo_reg;
    logic [7:0] modeHi_reg;
    logic [2*NPIN-1:0] func_reg;
    logic [NPIN-1:0] type_reg;
    logic [31:0] prdata_reg;
    logic err_reg;
    logic [NPIN-1:0] pinOut_reg;
    logic [NPIN-1:0] pinOutEn_n_reg;
    logic [NPIN-1:0] pinActive_reg;
    logic sysEn_reg;
    logic pwrEn_reg;
    logic pwr1En_reg;

    logic [NPIN-1:0] mode;
    gmb_pkg::gmb_fn_t fnv [NPIN];
    logic [NPIN-1:0] isIn;
    logic [NPIN-1:0] drive;
    logic [NPIN-1:0] od;
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] active;
    logic [NPIN-1:0] debEn;
    logic [NPIN-1:0] debClean;
    logic [31:0] rdMux;
    logic rdHit;
    logic [5:0] idx;
    logic setup;
    logic access;
    logic wrEn;

    gmb_deb_if #(.N(NPIN)) deb();

    assign mode = {modeHi_reg, modeLo_reg};
    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wrEn = access && pwrite && rdHit;

    for (genvar g = 0; g < NPIN; g++) begin : g_fn
        assign fnv[g] = gmb_pkg::gmb_fn_t'(func_reg[2*g +: 2]);
    end

    // ---------------------------------------------
    // apb slave
    // ---------------------------------------------
    always_comb begin
        rdMux = 32'h0;
        rdHit = (paddr[1:0] == 2'h0);
        unique case (idx)
            gmb_pkg::IDX_MODE_LO: rdMux = {24'h0, modeLo_reg};
            gmb_pkg::IDX_MODE_HI: rdMux = {24'h0, modeHi_reg};
            gmb_pkg::IDX_RSVD: rdMux = 32'h0;
            gmb_pkg::IDX_FUNC: rdMux = func_reg;
            gmb_pkg::IDX_TYPE: rdMux = {16'h0, type_reg};
            gmb_pkg::IDX_STAT: rdMux = {pinActive_reg, debClean};
            default: rdHit = 1'h0;
        endcase
    end

    // read data and error captured in setup
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0;
            err_reg <= 1'h0;
        end else if (setup) begin
            prdata_reg <= rdHit ? rdMux : 32'h0;
            err_reg <= !rdHit;
        end
    end

    assign prdata = prdata_reg;
    assign pready = access;
    assign pslverr = access && err_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            modeLo_reg <= gmb_pkg::MODE_RST;
            modeHi_reg <= gmb_pkg::MODE_RST;
            func_reg <= gmb_pkg::FUNC_RST;
            type_reg <= gmb_pkg::TYPE_RST;
        end else if (wrEn) begin
            if (idx == gmb_pkg::IDX_MODE_LO) begin
                modeLo_reg <= pwdata[7:0];
            end
            if (idx == gmb_pkg::IDX_MODE_HI) begin
                modeHi_reg <= pwdata[7:0];
            end
            if (idx == gmb_pkg::IDX_FUNC) begin
                func_reg <= pwdata;
            end
            if (idx == gmb_pkg::IDX_TYPE) begin
                type_reg <= pwdata[15:0];
            end
        end
    end

    // ---------------------------------------------
    // pin function decode
    // ---------------------------------------------
    always_comb begin
        isIn = '0;
        drive = '0;
        od = '0;
        lvl = '0;
        for (int i = 0; i < NPIN; i++) begin
            unique case (fnv[i])
                gmb_pkg::FN_IN: begin
                    isIn[i] = 1'h1;
                end
                gmb_pkg::FN_SW: begin
                    drive[i] = 1'h1;
                    od[i] = (i == gmb_pkg::PIN_CLK);
                    lvl[i] = mode[i];
                end
                gmb_pkg::FN_SEQ: begin
                    if (i == gmb_pkg::PIN_FAULT) begin
                        drive[i] = 1'h1;
                        lvl[i] = vsysMonitor ~^ mode[i];
                    end else if (i == gmb_pkg::PIN_FB) begin
                        drive[i] = 1'h1;
                        od[i] = 1'h1;
                        lvl[i] = fbReady ~^ mode[i];
                    end else if (gmb_pkg::SERIAL_MASK[i]) begin
                        isIn[i] = 1'h1;
                    end else begin
                        drive[i] = 1'h1;
                        od[i] = gmb_pkg::OD_SEQ_MASK[i];
                        if (gmb_pkg::SEQ_POL_MASK[i]) begin
                            lvl[i] = seqAssert[i] ~^ mode[i];
                        end else begin
                            lvl[i] = seqAssert[i];
                        end
                    end
                end
                gmb_pkg::FN_ALT: begin
                    if (gmb_pkg::BLINK_MASK[i]) begin
                        drive[i] = 1'h1;
                        od[i] = 1'h1;
                        lvl[i] = blinkPulse ^ mode[i];
                    end else if (i == gmb_pkg::PIN_FAULT) begin
                        drive[i] = 1'h1;
                        lvl[i] = supplyFault ~^ mode[i];
                    end else if (i == gmb_pkg::PIN_FB) begin
                        drive[i] = 1'h1;
                        lvl[i] = fbReady ~^ mode[i];
                    end else begin
                        isIn[i] = 1'h1;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------
    // pin drivers, open drain only pulls low
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pinOut_reg <= '0;
            pinOutEn_n_reg <= '1;
        end else begin
            pinOut_reg <= drive & ~od & lvl;
            pinOutEn_n_reg <= ~(drive & ~(od & lvl));
        end
    end

    assign pinOut = pinOut_reg;
    assign pinOutEn_n = pinOutEn_n_reg;

    // ---------------------------------------------
    // input path
    // ---------------------------------------------
    assign debEn = isIn & mode;
    assign deb.raw = pinIn;
    assign deb.en = debEn;
    assign debClean = deb.clean;
    assign active = debClean ~^ type_reg;

    gmb_debounce #(
        .N(NPIN),
        .CYCLES(DEB_CYCLES)
    ) u_deb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dbus(deb.filt)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pinActive_reg <= '0;
        end else begin
            pinActive_reg <= active & isIn;
        end
    end

    // shared control inputs follow the same filtered pins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sysEn_reg <= 1'h0;
            pwrEn_reg <= 1'h0;
            pwr1En_reg <= 1'h0;
        end else begin
            sysEn_reg <= active[gmb_pkg::PIN_SYS] && fnv[gmb_pkg::PIN_SYS] == gmb_pkg::FN_ALT;
            pwrEn_reg <= active[gmb_pkg::PIN_PWR] && fnv[gmb_pkg::PIN_PWR] == gmb_pkg::FN_ALT;
            pwr1En_reg <= active[gmb_pkg::PIN_PWR1]
                && fnv[gmb_pkg::PIN_PWR1] == gmb_pkg::FN_ALT;
        end
    end

    assign pinActive = pinActive_reg;
    assign sysEnable = sysEn_reg;
    assign pwrEnable = pwrEn_reg;
    assign pwr1Enable = pwr1En_reg;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    // checks wait one edge after release, until state has left reset
    logic chkArm_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chkArm_reg <= 1'h0;
        end else begin
            chkArm_reg <= 1'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !chkArm_reg);

    a_deb_bypass: assert property (
        (isIn[2] && !mode[2]) ##1 (isIn[2] && !mode[2])
        |-> debClean[2] == $past(pinIn[2]))
        else $error("bypassed input not following pin");

    a_sw_level: assert property (
        fnv[0] == gmb_pkg::FN_SW
        |=> pinOut[0] == $past(mode[0]) && !pinOutEn_n[0])
        else $error("software output level wrong");

    a_seq_polarity: assert property (
        fnv[3] == gmb_pkg::FN_SEQ
        |=> pinOut[3] == $past(seqAssert[3] ~^ mode[3]) && !pinOutEn_n[3])
        else $error("sequencer polarity wrong");

    a_blink_polarity: assert property (
        fnv[11] == gmb_pkg::FN_ALT
        |=> pinOutEn_n[11] == $past(blinkPulse ^ mode[11]) && !pinOut[11])
        else $error("blink polarity wrong");

    a_fb_polarity: assert property (
        fnv[13] == gmb_pkg::FN_ALT
        |=> pinOut[13] == $past(fbReady ~^ mode[13]) && !pinOutEn_n[13])
        else $error("feedback polarity wrong");

    a_fault_polarity: assert property (
        fnv[12] == gmb_pkg::FN_ALT
        |=> pinOut[12] == $past(supplyFault ~^ mode[12]))
        else $error("fault output polarity wrong");

    a_ctrl_share: assert property (
        fnv[8] == gmb_pkg::FN_ALT
        |-> debEn[8] == mode[8] ##1 sysEnable == pinActive[8])
        else $error("system enable not sharing pin filter");

    a_func_input: assert property (
        fnv[5] == gmb_pkg::FN_IN |-> isIn[5] ##1 pinOutEn_n[5])
        else $error("input pin is being driven");

    a_type_sense: assert property (
        isIn[4] |=> pinActive[4] == $past(debClean[4] ~^ type_reg[4]))
        else $error("input sense wrong");

    a_apb_unmapped: assert property (
        (setup && !rdHit) |=> !access || (pslverr && prdata == 32'h0))
        else $error("unmapped access not flagged");

    a_mode_write: assert property (
        (wrEn && idx == gmb_pkg::IDX_MODE_HI) |=> modeHi_reg == $past(pwdata[7:0]))
        else $error("mode write lost");

    c_blink_out: cover property (fnv[11] == gmb_pkg::FN_ALT && blinkPulse);
    c_mode_write: cover property (wrEn && idx == gmb_pkg::IDX_MODE_LO);
    c_sys_enable: cover property ($rose(sysEnable));
    c_bus_error: cover property (pslverr);
endmodule

// ===== src/gmb_pkg.sv
// What this block does
// - input pin: mode 1 debounces, 0 bypasses
// - software output: mode sets driven level
// - sequencer pins 3,4,6,7,9: mode sets polarity
// - blink pins 11,14,15: mode 0 active high
// - pin 13 feedback output: mode sets polarity
// - pin 12 fault/monitor output: mode sets polarity
// - pins 8-10 debounce also feeds enables
// - function field picks alternate, input, sequencer, software
// - type bit sets input active sense
package gmb_pkg;
    localparam int NPIN = 16;
    localparam int AW = 8;

    // ---------------------------------------------
    // register indices, byte address is index * 4
    // ---------------------------------------------
    localparam logic [5:0] IDX_MODE_LO = 6'h1d;
    localparam logic [5:0] IDX_MODE_HI = 6'h1e;
    localparam logic [5:0] IDX_RSVD = 6'h1f;
    localparam logic [5:0] IDX_FUNC = 6'h30;
    localparam logic [5:0] IDX_TYPE = 6'h31;
    localparam logic [5:0] IDX_STAT = 6'h32;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [31:0] FUNC_RST = 32'h5555_5555;
    localparam logic [15:0] TYPE_RST = 16'h0000;

    typedef enum logic [1:0] {
        FN_ALT = 2'h0,
        FN_IN = 2'h1,
        FN_SEQ = 2'h2,
        FN_SW = 2'h3
    } gmb_fn_t;

    // ---------------------------------------------
    // per-pin capabilities
    // ---------------------------------------------
    localparam logic [15:0] SEQ_POL_MASK = 16'h02d8;
    localparam logic [15:0] BLINK_MASK = 16'hc800;
    localparam logic [15:0] OD_SEQ_MASK = 16'h0400;
    localparam logic [15:0] SERIAL_MASK = 16'hc000;
    localparam int PIN_SYS = 8;
    localparam int PIN_PWR = 9;
    localparam int PIN_PWR1 = 10;
    localparam int PIN_FAULT = 12;
    localparam int PIN_FB = 13;
    localparam int PIN_CLK = 15;

    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEB_TIME_NS = 10000;
    localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== src/gmb_deb_if.sv
`timescale 1ns/1ps
interface gmb_deb_if #(parameter int N = 16);
    logic [N-1:0] raw;
    logic [N-1:0] en;
    logic [N-1:0] clean;
    modport filt(input raw, input en, output clean);
    modport user(output raw, output en, input clean);
endinterface

// ===== src/gmb_debounce.sv
`timescale 1ns/1ps
module gmb_debounce #(
    parameter int N = 16,
    parameter int CYCLES = gmb_pkg::DEB_CYCLES
) (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // sync reset
    gmb_deb_if.filt dbus // raw in, clean out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_reg [N];
    logic [N-1:0] clean_reg;

    assign dbus.clean = clean_reg;

    // ---------------------------------------------
    // per-pin stability counters
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clean_reg <= '0;
            for (int i = 0; i < N; i++) begin
                cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!dbus.en[i]) begin
                    clean_reg[i] <= dbus.raw[i];
                    cnt_reg[i] <= '0;
                end else if (dbus.raw[i] == clean_reg[i]) begin
                    cnt_reg[i] <= '0;
                end else if (cnt_reg[i] == CNT_MAX) begin
                    clean_reg[i] <= dbus.raw[i];
                    cnt_reg[i] <= '0;
                end else begin
                    cnt_reg[i] <= cnt_reg[i] + CW'(1);
                end
            end
        end
    end

    for (genvar g = 0; g < N; g++) begin : g_chk
        a_deb_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
            (dbus.en[g] && $past(dbus.en[g]) && $changed(clean_reg[g]))
            |-> $past(cnt_reg[g]) == CNT_MAX)
            else $error("debounced level changed before stable count");
    end
endmodule

// ===== test/gmb_board.sv
`timescale 1ns/1ps
module gmb_board (
    input wire logic [15:0] pinOut, // device level
    input wire logic [15:0] pinOutEn_n, // device drives when low
    input wire logic [15:0] drvVal, // board level
    input wire logic [15:0] drvEn, // board drives
    output logic [15:0] pinIn // resolved pin
);
    // device wins, then board, pull-up when floating
    assign pinIn = (~pinOutEn_n & pinOut) | (pinOutEn_n & drvEn & drvVal)
        | (pinOutEn_n & ~drvEn);
endmodule

// ===== test/gmb_top_tb.sv
`timescale 1ns/1ps
module gmb_top_tb;
    localparam int DEB = 4;
    localparam logic [7:0] A_LO = {gmb_pkg::IDX_MODE_LO, 2'b00};
    localparam logic [7:0] A_HI = {gmb_pkg::IDX_MODE_HI, 2'b00};
    localparam logic [7:0] A_RS = {gmb_pkg::IDX_RSVD, 2'b00};
    localparam logic [7:0] A_FN = {gmb_pkg::IDX_FUNC, 2'b00};
    localparam logic [7:0] A_TY = {gmb_pkg::IDX_TYPE, 2'b00};
    localparam logic [7:0] A_ST = {gmb_pkg::IDX_STAT, 2'b00};
    localparam logic [15:0] SEQ = gmb_pkg::SEQ_POL_MASK;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] pinIn;
    logic [15:0] pinOut;
    logic [15:0] pinOutEn_n;
    logic [15:0] pinActive;
    logic [15:0] seqAssert = 16'h0;
    logic [15:0] drvVal = 16'h0;
    logic [15:0] drvEn = 16'hffff;
    logic blinkPulse = 1'b0;
    logic fbReady = 1'b0;
    logic supplyFault = 1'b0;
    logic vsysMonitor = 1'b0;
    logic sysEnable;
    logic pwrEnable;
    logic pwr1Enable;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    gmb_top #(.DEB_CYCLES(DEB)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
        .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .seqAssert(seqAssert),
        .blinkPulse(blinkPulse), .fbReady(fbReady), .supplyFault(supplyFault),
        .vsysMonitor(vsysMonitor), .pinActive(pinActive), .sysEnable(sysEnable),
        .pwrEnable(pwrEnable), .pwr1Enable(pwr1Enable));
    gmb_board board_u (.pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .drvVal(drvVal),
        .drvEn(drvEn), .pinIn(pinIn));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------
    // helpers
    // ------------------------------
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // r returns {pslverr, prdata}
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [32:0] r);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(a, 1'b1, d, r);
    endtask

    task automatic setmode(input logic [15:0] m);
        wr(A_LO, {24'h0, m[7:0]});
        wr(A_HI, {24'h0, m[15:8]});
        @(posedge sys_clk);
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_regs();
        logic [32:0] r;
        apb(A_LO, 1'b0, 32'h0, r);
        chk(r, {25'h0, gmb_pkg::MODE_RST}, "mode low reset");
        apb(A_HI, 1'b0, 32'h0, r);
        chk(r, {25'h0, gmb_pkg::MODE_RST}, "mode high reset");
        apb(A_FN, 1'b0, 32'h0, r);
        chk(r, {1'b0, gmb_pkg::FUNC_RST}, "function reset");
        apb(A_TY, 1'b0, 32'h0, r);
        chk(r, {17'h0, gmb_pkg::TYPE_RST}, "type reset");
        wr(A_LO, 32'h1234_56a5);
        wr(A_HI, 32'h0000_005a);
        apb(A_LO, 1'b0, 32'h0, r);
        chk(r, 33'h0_0000_00a5, "mode low rw");
        apb(A_HI, 1'b0, 32'h0, r);
        chk(r, 33'h0_0000_005a, "mode high rw");
        wr(A_RS, 32'h0000_00ff);
        apb(A_RS, 1'b0, 32'h0, r);
        chk(r, 33'h0, "reserved slot");
        apb(8'h00, 1'b0, 32'h0, r);
        chk(r, {1'b1, 32'h0}, "unmapped read");
        apb(A_LO + 8'h01, 1'b1, 32'h0, r);
        chk(r, {1'b1, 32'h0}, "misaligned write");
        apb(A_LO, 1'b0, 32'h0, r);
        chk(r, 33'h0_0000_00a5, "misaligned write ignored");
    endtask

    task automatic t_sw();
        logic [15:0] p;
        wr(A_FN, 32'hffff_ffff);
        for (int i = 0; i < 3; i++) begin
            p = (i == 0) ? 16'h0000 : ((i == 1) ? 16'ha55a : 16'hffff);
            setmode(p);
            step(1);
            chk({17'h0, pinOut}, {17'h0, 1'b0, p[14:0]}, "sw level");
            chk({17'h0, pinOutEn_n}, {17'h0, p[15], 15'h0}, "sw enable");
        end
    endtask

    task automatic t_seq();
        logic [15:0] m;
        logic [15:0] s;
        wr(A_FN, 32'haaaa_aaaa);
        for (int i = 0; i < 4; i++) begin
            m = i[0] ? 16'hffff : 16'h0000;
            s = i[1] ? 16'h06d8 : 16'h0148;
            setmode(m);
            seqAssert <= s;
            vsysMonitor <= i[1];
            step(2);
            chk({17'h0, pinOut & SEQ}, {17'h0, ~(s ^ m) & SEQ}, "seq level");
            chk({17'h0, pinOutEn_n & SEQ}, 33'h0, "seq enable");
            chk({32'h0, pinOut[12]}, {32'h0, ~(i[1] ^ m[0])}, "vsys level");
            chk({31'h0, pinOutEn_n[10], pinOut[10]}, {31'h0, s[10], 1'b0}, "seq od");
            chk({30'h0, pinOutEn_n[15:13]}, {30'h0, 2'b11, ~m[0]}, "seq fb serial");
        end
    endtask

    task automatic t_misc();
        logic m;
        logic p;
        wr(A_FN, 32'h0);
        for (int i = 0; i < 4; i++) begin
            m = i[0];
            p = i[1];
            setmode({{8{m}}, 8'h00});
            blinkPulse <= p;
            supplyFault <= p;
            fbReady <= ~p;
            step(2);
            chk({30'h0, pinOutEn_n[15:14], pinOutEn_n[11]}, {30'h0, {3{p ^ m}}}, "blink");
            chk({31'h0, pinOut[13:12]}, {31'h0, ~(~p ^ m), ~(p ^ m)}, "fb fault");
        end
    endtask

    task automatic t_deb();
        int n;
        wr(A_FN, 32'h5540_5555);
        wr(A_TY, 32'h0000_0101);
        setmode(16'h0100);
        drvVal <= 16'h0001;
        drvEn <= 16'hfffb;
        step(2);
        chk({17'h0, pinActive & 16'h0007}, 33'h3, "bypass");
        chk({30'h0, sysEnable, pwrEnable, pwr1Enable}, 33'h3, "enables");
        @(posedge sys_clk);
        drvVal[8] <= 1'b1;
        repeat (DEB - 1) @(posedge sys_clk);
        drvVal[8] <= 1'b0;
        step(DEB + 3);
        chk({32'h0, sysEnable}, 33'h0, "glitch rejected");
        @(posedge sys_clk);
        drvVal[8] <= 1'b1;
        step(DEB - 1);
        chk({32'h0, sysEnable}, 33'h0, "too early");
        n = 0;
        while (sysEnable !== 1'b1 && n < 4 * DEB) begin
            step(1);
            n++;
        end
        chk({31'h0, sysEnable, n == 2}, 33'h3, "accepted");
    endtask

    task automatic t_rst();
        logic [32:0] r;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        step(3);
        chk({17'h0, pinOutEn_n}, {17'h0, 16'hffff}, "reset releases pins");
        chk({17'h0, pinOut}, 33'h0, "reset levels");
        chk({14'h0, pinActive, sysEnable, pwrEnable, pwr1Enable}, 33'h0, "reset inputs");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(A_HI, 1'b0, 32'h0, r);
        chk(r, {25'h0, gmb_pkg::MODE_RST}, "mode after reset");
        apb(A_ST, 1'b0, 32'h0, r);
        chk(r, {1'b0, ~pinIn, pinIn}, "status after reset");
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_sw();
        t_seq();
        t_misc();
        t_deb();
        t_rst();
        final_report();
    end
endmodule
